// ===== include/gppp_pkg.sv
// Constants, register map and state type of the general-purpose pin ports.
package gppp_pkg;
  localparam int NPORT = 4;
  localparam int PORT_W = 8;
  localparam int PORT3_W = 5;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int PORT_SEL_LSB = 5;
  localparam int PORT_SEL_MSB = 6;
  localparam int OFF_MSB = 4;
  localparam int ADDR_TOP = 7;
  localparam int OUT_ONLY_PORT = 1;
  localparam int OUT_ONLY_BIT = 5;

  // Register offsets inside one port's 32-byte window.
  localparam logic [4:0] OFF_DOUT = 5'h00;
  localparam logic [4:0] OFF_DIR = 5'h04;
  localparam logic [4:0] OFF_OTYPE = 5'h08;
  localparam logic [4:0] OFF_PULL = 5'h0C;
  localparam logic [4:0] OFF_DIN = 5'h10;
  localparam logic [4:0] OFF_IEN = 5'h14;
  localparam logic [4:0] OFF_ISTAT = 5'h18;

  // Per-port masks, port 3 in the top byte.
  localparam logic [3:0][7:0] IMPL_MASK = {8'h1F, 8'hFF, 8'hFF, 8'hFF};
  localparam logic [3:0][7:0] IRQ_MASK = {8'h00, 8'h00, 8'hFF, 8'hFF};
  localparam logic [3:0][7:0] FORCE_OUT = {8'h00, 8'h00, 8'h20, 8'h00};

  // Reset values.
  localparam logic [3:0][7:0] DOUT_RST = {8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [3:0][7:0] DIR_RST = FORCE_OUT;
  localparam logic [3:0][7:0] OTYPE_RST = FORCE_OUT;
  localparam logic [3:0][7:0] PULL_RST = {8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [3:0][7:0] IEN_RST = {8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [3:0][7:0] ZERO_PORTS = {8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [2:0] ZERO_3 = 3'h0;

  typedef struct packed {
    logic [3:0][7:0] dout;
    logic [3:0][7:0] dir;
    logic [3:0][7:0] otype;
    logic [3:0][7:0] pull;
    logic [3:0][7:0] ien;
    logic [3:0][7:0] istat;
    logic [3:0][7:0] sync1;
    logic [3:0][7:0] sync2;
    logic [3:0][7:0] sync3;
    logic [3:0][7:0] filt;
    logic [7:0] rdata;
  } gppp_state_type;
endpackage

// ===== rtl/gppp_pin_ports.sv
// General-purpose pin ports with register access and pin-change interrupts.
// Function
// - Each pin except port 1 bit 5 independently input or bidirectional.
// - Per-pin static pull-up enable.
// - Per-pin open-drain or push-pull output; port 1 bit 5 fixed push-pull.
// - Port 0 pin changes raise maskable interrupts.
// - Port 1 matches port 0, interrupts included, except output-only bit 5, which raises no interrupt.
// - Port 1 bit 5 output only, low after reset.
// - Port 2 configurable, no interrupt capability.
// - Port 3 has bits 0-4 only, no interrupts.
//
// The strobed register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module gppp_pin_ports
  import gppp_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic [gppp_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [gppp_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [gppp_pkg::DATA_W-1:0] reg_rdata_o,
  output logic irq_o,
  input wire logic [gppp_pkg::PORT_W-1:0] port0_pins_i,
  output logic [gppp_pkg::PORT_W-1:0] port0_pins_o,
  output logic [gppp_pkg::PORT_W-1:0] port0_pins_oe_n_o,
  output logic [gppp_pkg::PORT_W-1:0] port0_pins_pullup_o,
  input wire logic [gppp_pkg::PORT_W-1:0] port1_pins_i,
  output logic [gppp_pkg::PORT_W-1:0] port1_pins_o,
  output logic [gppp_pkg::PORT_W-1:0] port1_pins_oe_n_o,
  output logic [gppp_pkg::PORT_W-1:0] port1_pins_pullup_o,
  input wire logic [gppp_pkg::PORT_W-1:0] port2_pins_i,
  output logic [gppp_pkg::PORT_W-1:0] port2_pins_o,
  output logic [gppp_pkg::PORT_W-1:0] port2_pins_oe_n_o,
  output logic [gppp_pkg::PORT_W-1:0] port2_pins_pullup_o,
  input wire logic [gppp_pkg::PORT3_W-1:0] port3_pins_i,
  output logic [gppp_pkg::PORT3_W-1:0] port3_pins_o,
  output logic [gppp_pkg::PORT3_W-1:0] port3_pins_oe_n_o,
  output logic [gppp_pkg::PORT3_W-1:0] port3_pins_pullup_o
);
  import gppp_pkg::*;

  gppp_state_type st_ff;
  gppp_state_type nxt_st;
  logic [3:0][7:0] pin_in;
  logic [3:0][7:0] oe_n;
  logic [3:0][7:0] din_view;
  logic [3:0][7:0] events;
  logic [1:0] sel_port;
  logic [4:0] sel_off;
  logic sel_hit;
  logic [7:0] wbyte;

  assign pin_in = {ZERO_3, port3_pins_i, port2_pins_i, port1_pins_i,
                   port0_pins_i};
  assign sel_port = reg_addr_i[PORT_SEL_MSB:PORT_SEL_LSB];
  assign sel_off = reg_addr_i[OFF_MSB:0];
  assign sel_hit = ~reg_addr_i[ADDR_TOP];
  assign wbyte = reg_wdata_i[7:0];

  genvar gp;
  generate
    for (gp = 0; gp < NPORT; gp++) begin : g_port
      // A pin drives when it is an output and, in open-drain mode, only
      // while its data bit is low; otherwise the enable stays high.
      assign oe_n[gp] = ~(st_ff.dir[gp] & IMPL_MASK[gp] &
                          (st_ff.otype[gp] | ~st_ff.dout[gp]));
      // The output-only pin reads back its own driven value.
      assign din_view[gp] = ((st_ff.filt[gp] & ~FORCE_OUT[gp]) |
                             (st_ff.dout[gp] & FORCE_OUT[gp])) &
                            IMPL_MASK[gp];
      // A settled change on an interrupt-capable pin is an event. It is
      // worked out from the registers so that the next-state logic does
      // not read its own output.
      assign events[gp] = ~(st_ff.sync2[gp] ^ st_ff.sync3[gp]) &
                          (st_ff.sync3[gp] ^ st_ff.filt[gp]) &
                          IRQ_MASK[gp] & ~FORCE_OUT[gp];
    end
  endgenerate

  always_comb begin
    nxt_st = st_ff;
    // Three-stage synchroniser; the filter follows only when stages agree.
    nxt_st.sync1 = pin_in;
    nxt_st.sync2 = st_ff.sync1;
    nxt_st.sync3 = st_ff.sync2;
    nxt_st.filt = (~(st_ff.sync2 ^ st_ff.sync3) & st_ff.sync3) |
                  ((st_ff.sync2 ^ st_ff.sync3) & st_ff.filt);
    nxt_st.rdata = ZERO_BYTE;
    if (reg_wr_i && sel_hit) begin
      unique case (sel_off)
        OFF_DOUT: begin
          nxt_st.dout[sel_port] = wbyte & IMPL_MASK[sel_port];
        end
        OFF_DIR: begin
          nxt_st.dir[sel_port] = (wbyte & IMPL_MASK[sel_port]) |
                                 FORCE_OUT[sel_port];
        end
        OFF_OTYPE: begin
          nxt_st.otype[sel_port] = (wbyte & IMPL_MASK[sel_port]) |
                                   FORCE_OUT[sel_port];
        end
        OFF_PULL: begin
          nxt_st.pull[sel_port] = wbyte & IMPL_MASK[sel_port];
        end
        OFF_IEN: begin
          nxt_st.ien[sel_port] = wbyte & IRQ_MASK[sel_port];
        end
        default: begin
        end
      endcase
    end
    if (reg_rd_i && sel_hit) begin
      unique case (sel_off)
        OFF_DOUT: nxt_st.rdata = st_ff.dout[sel_port];
        OFF_DIR: nxt_st.rdata = st_ff.dir[sel_port];
        OFF_OTYPE: nxt_st.rdata = st_ff.otype[sel_port];
        OFF_PULL: nxt_st.rdata = st_ff.pull[sel_port];
        OFF_DIN: nxt_st.rdata = din_view[sel_port];
        OFF_IEN: nxt_st.rdata = st_ff.ien[sel_port];
        OFF_ISTAT: begin
          nxt_st.rdata = st_ff.istat[sel_port];
          nxt_st.istat[sel_port] = ZERO_BYTE;
        end
        default: nxt_st.rdata = ZERO_BYTE;
      endcase
    end
    // A new event wins over a clearing read in the same cycle.
    nxt_st.istat = nxt_st.istat | events;
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_ff.dout <= DOUT_RST;
      st_ff.dir <= DIR_RST;
      st_ff.otype <= OTYPE_RST;
      st_ff.pull <= PULL_RST;
      st_ff.ien <= IEN_RST;
      st_ff.istat <= ZERO_PORTS;
      st_ff.sync1 <= ZERO_PORTS;
      st_ff.sync2 <= ZERO_PORTS;
      st_ff.sync3 <= ZERO_PORTS;
      st_ff.filt <= ZERO_PORTS;
      st_ff.rdata <= ZERO_BYTE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata_o = {{(DATA_W-PORT_W){1'b0}}, st_ff.rdata};
  assign irq_o = |(st_ff.istat & st_ff.ien);

  assign port0_pins_o = st_ff.dout[0];
  assign port0_pins_oe_n_o = oe_n[0];
  assign port0_pins_pullup_o = st_ff.pull[0];
  assign port1_pins_o = st_ff.dout[1];
  assign port1_pins_oe_n_o = oe_n[1];
  assign port1_pins_pullup_o = st_ff.pull[1];
  assign port2_pins_o = st_ff.dout[2];
  assign port2_pins_oe_n_o = oe_n[2];
  assign port2_pins_pullup_o = st_ff.pull[2];
  assign port3_pins_o = st_ff.dout[3][PORT3_W-1:0];
  assign port3_pins_oe_n_o = oe_n[3][PORT3_W-1:0];
  assign port3_pins_pullup_o = st_ff.pull[3][PORT3_W-1:0];

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  sequence s_p0_change;
    (st_ff.filt[0][0] != st_ff.sync3[0][0]) &&
    (st_ff.sync2[0][0] == st_ff.sync3[0][0]);
  endsequence
  sequence s_p0_armed;
    st_ff.ien[0][0] && !reg_wr_i;
  endsequence
  sequence s_p1_change;
    (st_ff.filt[1][0] != st_ff.sync3[1][0]) &&
    (st_ff.sync2[1][0] == st_ff.sync3[1][0]);
  endsequence
  sequence s_p1_armed;
    st_ff.ien[1][0] && !reg_wr_i;
  endsequence

  a_input_only_undriven: assert property (
    (reg_wr_i && reg_addr_i == {3'h0, OFF_DIR} && wbyte == ZERO_BYTE)
    |=> port0_pins_oe_n_o == 8'hFF)
    else $error("Port 0 pins driven after being made inputs.");

  a_pullup_follows_write: assert property (
    (reg_wr_i && reg_addr_i == {3'h2, OFF_PULL})
    |=> port2_pins_pullup_o == $past(wbyte))
    else $error("Port 2 pull-up enables do not follow the write.");

  a_open_drain_high: assert property (
    (~port0_pins_oe_n_o & port0_pins_o & ~st_ff.otype[0]) == ZERO_BYTE)
    else $error("Open-drain pin drives a high level.");

  a_p0_change_irq: assert property (
    (s_p0_change and s_p0_armed) |=> irq_o ##1 1'b1)
    else $error("Port 0 pin change raised no interrupt.");

  a_p1_change_irq: assert property (
    (s_p1_change and s_p1_armed) |=> irq_o && st_ff.istat[1][0])
    else $error("Port 1 pin change raised no interrupt.");

  a_out_only_driven: assert property (
    !port1_pins_oe_n_o[OUT_ONLY_BIT])
    else $error("Output-only pin is not driven.");

  a_out_only_low: assert property (
    $past(reset_n_i) == 1'b0 |-> !port1_pins_o[OUT_ONLY_BIT])
    else $error("Output-only pin not low after reset.");

  a_event_beats_clear: assert property (
    (events[0][0] && reg_rd_i && reg_addr_i == {3'h0, OFF_ISTAT})
    |=> st_ff.istat[0][0])
    else $error("Clearing read lost a same-cycle event.");

  a_p3_write_dropped: assert property (
    st_ff.dout[3][7:PORT3_W] == ZERO_3 &&
    st_ff.dir[3][7:PORT3_W] == ZERO_3 &&
    st_ff.pull[3][7:PORT3_W] == ZERO_3)
    else $error("Port 3 missing bits took a write.");

  a_no_irq_p2p3: assert property (
    st_ff.istat[2] == ZERO_BYTE && st_ff.istat[3] == ZERO_BYTE &&
    st_ff.ien[2] == ZERO_BYTE && st_ff.ien[3] == ZERO_BYTE)
    else $error("Port 2 or 3 holds interrupt state.");

  a_p3_upper_zero: assert property (
    (reg_rd_i && sel_hit && sel_port == 2'h3)
    |=> reg_rdata_o[7:PORT3_W] == ZERO_3)
    else $error("Port 3 missing bits do not read as zero.");

  a_rdata_one_cycle: assert property (
    !reg_rd_i |=> reg_rdata_o == {DATA_W{1'b0}})
    else $error("Read data present without a read.");
endmodule

// ===== sim/gppp_board.sv
// Board model of one pin port: settles the level seen on every pin.
`timescale 1ns/1ps
module gppp_board #(
  parameter int W = 8
) (
  input wire logic clk_i,
  input wire logic [W-1:0] pin_o_i,
  input wire logic [W-1:0] oe_n_i,
  input wire logic [W-1:0] pullup_i,
  input wire logic [W-1:0] ext_en_i,
  input wire logic [W-1:0] ext_val_i,
  output logic [W-1:0] level_o
);
  logic [W-1:0] last_ff;
  // A pin nobody drives and nothing pulls up keeps changing level.
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (!oe_n_i[i]) begin
        level_o[i] = pin_o_i[i];
      end else if (ext_en_i[i]) begin
        level_o[i] = ext_val_i[i];
      end else if (pullup_i[i]) begin
        level_o[i] = 1'b1;
      end else begin
        level_o[i] = ~last_ff[i];
      end
    end
  end
  always_ff @(posedge clk_i) begin
    last_ff <= level_o;
  end
endmodule

// ===== sim/test_general_purpose_pin_ports.sv
// Self-checking bench for the general-purpose pin ports.
`timescale 1ns/1ps
module test_general_purpose_pin_ports;
  import gppp_pkg::*;
  logic core_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic irq;
  logic [3:0][7:0] ev = '0;
  wire [3:0][7:0] po, oe, pu, lv;
  int failures = 0;
  int check_count = 0;
  always #5 core_clk_i = ~core_clk_i;
  assign po[3][7:5] = 3'h0;
  assign oe[3][7:5] = 3'h7;
  assign pu[3][7:5] = 3'h0;
  assign lv[3][7:5] = 3'h0;
  gppp_pin_ports dut (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .irq_o(irq),
    .port0_pins_i(lv[0]), .port0_pins_o(po[0]),
    .port0_pins_oe_n_o(oe[0]), .port0_pins_pullup_o(pu[0]),
    .port1_pins_i(lv[1]), .port1_pins_o(po[1]),
    .port1_pins_oe_n_o(oe[1]), .port1_pins_pullup_o(pu[1]),
    .port2_pins_i(lv[2]), .port2_pins_o(po[2]),
    .port2_pins_oe_n_o(oe[2]), .port2_pins_pullup_o(pu[2]),
    .port3_pins_i(lv[3][4:0]), .port3_pins_o(po[3][4:0]),
    .port3_pins_oe_n_o(oe[3][4:0]), .port3_pins_pullup_o(pu[3][4:0]));
  for (genvar p = 0; p < 3; p++) begin : g_brd
    gppp_board #(.W(8)) brd (.clk_i(core_clk_i), .pin_o_i(po[p]),
      .oe_n_i(oe[p]), .pullup_i(pu[p]), .ext_en_i(8'hFF),
      .ext_val_i(ev[p]), .level_o(lv[p]));
  end
  gppp_board #(.W(5)) brd3 (.clk_i(core_clk_i), .pin_o_i(po[3][4:0]),
    .oe_n_i(oe[3][4:0]), .pullup_i(pu[3][4:0]), .ext_en_i(5'h1F),
    .ext_val_i(ev[3][4:0]), .level_o(lv[3][4:0]));
  function automatic logic [7:0] ad(logic [1:0] p, logic [4:0] o);
    return {1'b0, p, o};
  endfunction
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr_reg(logic [7:0] a, logic [7:0] d);
    @(posedge core_clk_i);
    wr <= 1'b1;
    addr <= a;
    wdata <= {24'h0, d};
    @(posedge core_clk_i);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(logic [7:0] a, logic [7:0] e, string n);
    @(posedge core_clk_i);
    rd <= 1'b1;
    addr <= a;
    @(posedge core_clk_i);
    rd <= 1'b0;
    #1 chk(n, e, rdata[7:0]);
  endtask
  task automatic rd_drop(logic [7:0] a);
    @(posedge core_clk_i);
    rd <= 1'b1;
    addr <= a;
    @(posedge core_clk_i);
    rd <= 1'b0;
  endtask
  task automatic t_reset;
    @(negedge core_clk_i);
    for (int p = 0; p < NPORT; p++) begin
      chk("oe_n", ~FORCE_OUT[p], oe[p]);
      chk("out", 8'h00, po[p]);
      chk("pullup", 8'h00, pu[p]);
    end
    chk("irq", 1'b0, irq);
    rd_reg(ad(1, OFF_DIR), 8'h20, "dir1");
  endtask
  task automatic t_config;
    logic [7:0] m, f;
    for (int p = 0; p < NPORT; p++) begin
      m = IMPL_MASK[p];
      f = FORCE_OUT[p];
      wr_reg(ad(p, OFF_DIR), 8'h5A);
      wr_reg(ad(p, OFF_DOUT), 8'hF6);
      wr_reg(ad(p, OFF_OTYPE), 8'hFF);
      wr_reg(ad(p, OFF_PULL), 8'hC3);
      @(negedge core_clk_i);
      chk("out", 8'hF6 & m, po[p]);
      chk("oe_pp", ~((8'h5A & m) | f), oe[p]);
      chk("pullup", 8'hC3 & m, pu[p]);
      wr_reg(ad(p, OFF_OTYPE), 8'h00);
      @(negedge core_clk_i);
      chk("oe_od", ~((8'h5A & ~8'hF6 & m) | f), oe[p]);
      rd_reg(ad(p, OFF_DIR), (8'h5A & m) | f, "dir");
      rd_reg(ad(p, OFF_PULL), 8'hC3 & m, "pull");
    end
  endtask
  task automatic t_irq;
    for (int p = 0; p < NPORT; p++) wr_reg(ad(p, OFF_DIR), 8'h00);
    wr_reg(ad(0, OFF_IEN), 8'h01);
    wr_reg(ad(1, OFF_IEN), 8'hFF);
    repeat (8) @(posedge core_clk_i);
    rd_drop(ad(0, OFF_ISTAT));
    rd_drop(ad(1, OFF_ISTAT));
    @(posedge core_clk_i);
    ev <= {8'h1F, 8'hFF, 8'hA0, 8'h03};
    repeat (6) @(posedge core_clk_i);
    #1 chk("irq", 1'b1, irq);
    rd_reg(ad(0, OFF_DIN), 8'h03, "din0");
    rd_reg(ad(1, OFF_DIN), 8'hA0, "din1");
    rd_reg(ad(2, OFF_DIN), 8'hFF, "din2");
    rd_reg(ad(3, OFF_DIN), 8'h1F, "din3");
    rd_reg(ad(0, OFF_ISTAT), 8'h03, "stat0");
    rd_reg(ad(1, OFF_ISTAT), 8'h80, "stat1");
    rd_reg(ad(2, OFF_ISTAT), 8'h00, "stat2");
    chk("irq", 1'b0, irq);
    @(posedge core_clk_i);
    ev[0] <= 8'h01;
    repeat (6) @(posedge core_clk_i);
    #1 chk("irq_mask", 1'b0, irq);
    rd_reg(ad(0, OFF_ISTAT), 8'h02, "stat0m");
    rd_reg(8'h80, 8'h00, "unmapped");
  endtask
  task automatic end_of_test;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    t_reset();
    t_config();
    t_irq();
    end_of_test();
  end
  initial begin
    #100us;
    failures++;
    end_of_test();
  end
endmodule
